// >>> rtl/flash_pwr_seq.sv
// Purpose: Power-up, power-down, reset pin recovery and rescue sequence detection.
// Assumes: Supply and link pins are asynchronous; core status inputs share CLK_SYS.
// Notes: Link clock is sampled, so it must run well below a quarter of CLK_SYS.
`timescale 1ns/1ps
`include "flash_pwr_map.svh"

module flash_pwr_seq #(
    parameter logic [31:0] PUP_CYCLES = 32'(`FP_PUP_CYCLES),
    parameter logic [31:0] RECOV_ARRAY_CYC = 32'(`FP_RECOV_ARRAY_CYC),
    parameter logic [31:0] STATUS_WR_CYC = 32'(`FP_STATUS_WR_CYC),
    parameter logic [31:0] NVCFG_WR_CYC = 32'(`FP_NVCFG_WR_CYC),
    parameter logic [31:0] SUBSECTOR_CYC = 32'(`FP_SUBSECTOR_CYC)
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Supply monitors
    input wire logic SUPPLY_ABOVE_POR,
    input wire logic SUPPLY_AT_MIN,
    // Serial link pins
    input wire flash_pwr_pkg::link_t LINK,
    // Core status
    input wire flash_pwr_pkg::op_kind_t BUSY_OP,
    input wire logic DUMMY_FIRST,
    input wire logic EXECUTE_IN_PLACE_ENABLE,
    input wire logic EXECUTE_IN_PLACE_BOOT,
    // Access control and status
    output logic CORE_RESET,
    output logic STATUS_ONLY,
    output logic FULL_ACCESS,
    output logic CLEAR_WEL_WIP,
    output logic LOCK_INIT,
    output logic EXECUTE_IN_PLACE_MODE,
    output logic EXT_SPI_FORCED,
    output logic RECOVERING
);
    import flash_pwr_pkg::*;

    // ====================================================================
    // Synchronisers
    link_t link_s1_reg, link_s2_reg, link_prev_reg;
    logic [1:0] sup_s1_reg, sup_s2_reg;
    logic por_ok, at_min;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            link_s1_reg <= '{sclk: 1'b0, sel_n: 1'b1, io0: 1'b0, io3: 1'b0, rst_n: 1'b1};
            link_s2_reg <= '{sclk: 1'b0, sel_n: 1'b1, io0: 1'b0, io3: 1'b0, rst_n: 1'b1};
            link_prev_reg <= '{sclk: 1'b0, sel_n: 1'b1, io0: 1'b0, io3: 1'b0, rst_n: 1'b1};
            sup_s1_reg <= 2'h0;
            sup_s2_reg <= 2'h0;
        end else begin
            link_s1_reg <= LINK;
            link_s2_reg <= link_s1_reg;
            link_prev_reg <= link_s2_reg;
            sup_s1_reg <= {SUPPLY_AT_MIN, SUPPLY_ABOVE_POR};
            sup_s2_reg <= sup_s1_reg;
        end
    end

    assign por_ok = sup_s2_reg[0];
    assign at_min = sup_s2_reg[1];

    // ====================================================================
    // Power and reset sequencer
    pwr_state_t state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [31:0] rec_reg, rec_next;
    logic [3:0] rlow_reg, rlow_next;
    logic clr_reg, clr_next;
    logic [31:0] rec_load;

    // Recovery length follows the operation that the reset interrupted.
    always_comb begin
        case (BUSY_OP)
            OP_ARRAY: rec_load = RECOV_ARRAY_CYC;
            OP_STATUS_WR: rec_load = STATUS_WR_CYC;
            OP_NVCFG_WR: rec_load = NVCFG_WR_CYC;
            OP_SUBSECTOR: rec_load = SUBSECTOR_CYC;
            default: rec_load = 32'(`FP_RECOV_FAST_CYC);
        endcase
    end

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        rec_next = rec_reg;
        rlow_next = 4'h0;
        clr_next = 1'b0;
        if (!link_s2_reg.rst_n && rlow_reg != 4'hF) begin
            rlow_next = rlow_reg + 4'h1;
        end
        case (state_reg)
            ST_OFF: begin
                cnt_next = 32'h0000_0000;
                if (por_ok && at_min) begin
                    state_next = ST_PUP;
                end
            end
            ST_PUP: begin
                cnt_next = cnt_reg + 32'h0000_0001;
                if (cnt_reg >= PUP_CYCLES - 32'h0000_0001) begin
                    state_next = ST_RUN;
                    clr_next = 1'b1;
                end
            end
            ST_RUN: begin
                // Short glitches are filtered so noise on the pin cannot reset the core.
                if (rlow_reg >= 4'(`FP_RST_PULSE_CYC) - 4'h1) begin
                    state_next = ST_HOLD;
                    rec_next = rec_load;
                end
            end
            ST_HOLD: begin
                cnt_next = 32'h0000_0000;
                if (link_s2_reg.rst_n) begin
                    state_next = ST_REC;
                end
            end
            ST_REC: begin
                cnt_next = cnt_reg + 32'h0000_0001;
                if (!link_s2_reg.rst_n) begin
                    state_next = ST_HOLD;
                end else if (cnt_reg >= rec_reg - 32'h0000_0001) begin
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_OFF;
        endcase
        if (!por_ok) begin
            state_next = ST_OFF;
            clr_next = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= ST_OFF;
            cnt_reg <= 32'h0000_0000;
            rec_reg <= 32'h0000_0000;
            rlow_reg <= 4'h0;
            clr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rec_reg <= rec_next;
            rlow_reg <= rlow_next;
            clr_reg <= clr_next;
        end
    end

    assign CORE_RESET = (state_reg == ST_OFF) || (state_reg == ST_HOLD);
    assign STATUS_ONLY = (state_reg == ST_PUP);
    assign FULL_ACCESS = (state_reg == ST_RUN);
    assign RECOVERING = (state_reg == ST_HOLD) || (state_reg == ST_REC);
    assign CLEAR_WEL_WIP = clr_reg;
    assign LOCK_INIT = clr_reg;

    // ====================================================================
    // Rescue frame detector and execute-in-place state
    logic [4:0] edges_reg, edges_next;
    logic good_reg, good_next;
    logic stage_reg, stage_next;
    logic exec_mode_reg, exec_mode_next;
    logic ext_reg, ext_next;
    logic sclk_rise, frame_end, part_one, part_two, listen;

    assign listen = (state_reg == ST_PUP) || (state_reg == ST_RUN) || (state_reg == ST_REC);
    assign sclk_rise = link_s2_reg.sclk && !link_prev_reg.sclk && !link_s2_reg.sel_n;
    assign frame_end = link_s2_reg.sel_n && !link_prev_reg.sel_n;
    assign part_one = frame_end && good_reg && ((edges_reg == `FP_RESCUE_A) ||
        (edges_reg == `FP_RESCUE_B) || (edges_reg == `FP_RESCUE_C));
    assign part_two = frame_end && good_reg && stage_reg && (edges_reg == `FP_RESCUE_FF);

    always_comb begin
        edges_next = edges_reg;
        good_next = good_reg;
        stage_next = stage_reg;
        exec_mode_next = exec_mode_reg;
        ext_next = ext_reg;
        if (link_s2_reg.sel_n) begin
            edges_next = 5'h00;
            good_next = 1'b1;
        end else if (sclk_rise) begin
            if (edges_reg != 5'h1F) begin
                edges_next = edges_reg + 5'h01;
            end
            good_next = good_reg && link_s2_reg.io0 && link_s2_reg.io3;
        end
        if (DUMMY_FIRST) begin
            exec_mode_next = !link_s2_reg.io0 && (exec_mode_reg || EXECUTE_IN_PLACE_ENABLE);
        end
        if (frame_end) begin
            stage_next = 1'b0;
        end
        if (part_one) begin
            stage_next = 1'b1;
            exec_mode_next = 1'b0;
        end else if (part_two) begin
            ext_next = 1'b1;
            exec_mode_next = 1'b0;
        end
        if (state_reg == ST_PUP && cnt_reg == 32'h0000_0000) begin
            exec_mode_next = EXECUTE_IN_PLACE_BOOT;
        end
        if (!listen) begin
            // A pin reset returns the mode to its boot setting, as a power cycle would.
            edges_next = 5'h00;
            good_next = 1'b1;
            stage_next = 1'b0;
            exec_mode_next = (state_reg == ST_HOLD) ? EXECUTE_IN_PLACE_BOOT : 1'b0;
            ext_next = (state_reg == ST_HOLD) ? ext_reg : 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            edges_reg <= 5'h00;
            good_reg <= 1'b1;
            stage_reg <= 1'b0;
            exec_mode_reg <= 1'b0;
            ext_reg <= 1'b0;
        end else begin
            edges_reg <= edges_next;
            good_reg <= good_next;
            stage_reg <= stage_next;
            exec_mode_reg <= exec_mode_next;
            ext_reg <= ext_next;
        end
    end

    assign EXECUTE_IN_PLACE_MODE = exec_mode_reg;
    assign EXT_SPI_FORCED = ext_reg;

    // ====================================================================
    // Assertions
    property p_por_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST) !por_ok |=> CORE_RESET && !FULL_ACCESS;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("core not held below threshold");

    property p_pup_status;
        @(posedge CLK_SYS) disable iff (SYS_RST) STATUS_ONLY |-> !FULL_ACCESS && !CORE_RESET;
    endproperty
    a_pup_status: assert property (p_pup_status) else $error("full access in power-up");

    property p_pup_clear;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            $fell(STATUS_ONLY) && FULL_ACCESS |-> CLEAR_WEL_WIP && LOCK_INIT;
    endproperty
    a_pup_clear: assert property (p_pup_clear) else $error("no clear after power-up");

    property p_pdown;
        @(posedge CLK_SYS) disable iff (SYS_RST) $fell(por_ok) |=> CORE_RESET ##1 CORE_RESET;
    endproperty
    a_pdown: assert property (p_pdown) else $error("operation after power-down");

    property p_pup_len;
        @(posedge CLK_SYS) disable iff (SYS_RST) STATUS_ONLY |-> cnt_reg < PUP_CYCLES;
    endproperty
    a_pup_len: assert property (p_pup_len) else $error("power-up phase too long");

    property p_rescue;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            part_two && listen && por_ok |=> EXT_SPI_FORCED && !EXECUTE_IN_PLACE_MODE;
    endproperty
    a_rescue: assert property (p_rescue) else $error("rescue did not force protocol");

    property p_rec_len;
        @(posedge CLK_SYS) disable iff (SYS_RST) state_reg == ST_REC |-> cnt_reg < rec_reg;
    endproperty
    a_rec_len: assert property (p_rec_len) else $error("recovery overran");

    property p_rec_array;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            state_reg == ST_RUN && state_next == ST_HOLD && BUSY_OP == OP_ARRAY
            |=> rec_reg == RECOV_ARRAY_CYC;
    endproperty
    a_rec_array: assert property (p_rec_array) else $error("array recovery length wrong");

    property p_rec_nvcfg;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            state_reg == ST_RUN && state_next == ST_HOLD && BUSY_OP == OP_NVCFG_WR
            |=> rec_reg == NVCFG_WR_CYC;
    endproperty
    a_rec_nvcfg: assert property (p_rec_nvcfg) else $error("config recovery length wrong");

    property p_mode_exit;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            DUMMY_FIRST && link_s2_reg.io0 |=> !EXECUTE_IN_PLACE_MODE;
    endproperty
    a_mode_exit: assert property (p_mode_exit) else $error("mode kept on confirmation one");

    c_pup_done: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) CLEAR_WEL_WIP);
    c_rescue: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) $rose(EXT_SPI_FORCED));
    c_pin_reset: cover property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_reg == ST_REC ##1 FULL_ACCESS);

endmodule : flash_pwr_seq

// >>> rtl/flash_pwr_map.svh
// Purpose: Offsets-free constant map for the flash power-up, reset and rescue block.
// Assumes: System clock of 200 MHz.
// Notes: Times are in their own units; cycle counts derive from them, except the status, config and subsector write counts, given in cycles.
`ifndef FLASH_PWR_MAP_SVH
`define FLASH_PWR_MAP_SVH

// ====================================================================
// Clock and timing
`define FP_CLK_MHZ 200
`define FP_PUP_TIME_US 150
`define FP_PUP_CYCLES (`FP_PUP_TIME_US * `FP_CLK_MHZ)
`define FP_RECOV_FAST_NS 40
`define FP_RECOV_FAST_CYC ((`FP_RECOV_FAST_NS * `FP_CLK_MHZ) / 1000)
`define FP_RECOV_ARRAY_US 30
`define FP_RECOV_ARRAY_CYC (`FP_RECOV_ARRAY_US * `FP_CLK_MHZ)
`define FP_RST_PULSE_NS 50
`define FP_RST_PULSE_CYC ((`FP_RST_PULSE_NS * `FP_CLK_MHZ + 999) / 1000)
`define FP_STATUS_WR_CYC 100000
`define FP_NVCFG_WR_CYC 100000
`define FP_SUBSECTOR_CYC 100000

// ====================================================================
// Rescue frame lengths in link clocks
`define FP_RESCUE_A 5'h07
`define FP_RESCUE_B 5'h0D
`define FP_RESCUE_C 5'h19
`define FP_RESCUE_FF 5'h08

`endif

// >>> rtl/flash_pwr_pkg.sv
// Purpose: Types shared by the flash power-up, reset and rescue block.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Link pins travel together as one packed struct.
package flash_pwr_pkg;

    // ====================================================================
    // Sequencer states
    typedef enum logic [2:0] {ST_OFF, ST_PUP, ST_RUN, ST_HOLD, ST_REC} pwr_state_t;

    // ====================================================================
    // Operation in progress when the reset pin acts
    typedef enum logic [2:0] {
        OP_IDLE, OP_ARRAY, OP_STATUS_WR, OP_NVCFG_WR, OP_SUBSECTOR
    } op_kind_t;

    // ====================================================================
    // Serial link pins as seen by the device
    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic io0;
        logic io3;
        logic rst_n;
    } link_t;

endpackage : flash_pwr_pkg

// >>> verif/host_ctl_model.sv
// Purpose: Behavioural host controller on the far side of the serial link.
// Assumes: Link pins are driven a small delay after CLK_SYS rising edges.
// Notes: Link clock runs at 160 ns and stands still low between frames.
`timescale 1ns/1ps

module host_ctl_model (
    // Clock
    input wire logic clk,
    // Link pins
    output flash_pwr_pkg::link_t link
);
    import flash_pwr_pkg::*;

    // ====================================================================
    // Timing
    localparam int HALF = 16;

    initial begin
        link = '{sclk: 1'h0, sel_n: 1'h1, io0: 1'h0, io3: 1'h0, rst_n: 1'h1};
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    // ====================================================================
    // Selected frame of n rising link edges with both data lines at val
    task automatic frame(input int n, input logic val);
        link.sel_n = 1'h0;
        link.io0 = val;
        link.io3 = val;
        wait_cyc(HALF);
        for (int i = 0; i < n; i++) begin
            link.sclk = 1'h1;
            wait_cyc(HALF);
            link.sclk = 1'h0;
            wait_cyc(HALF);
        end
        link.sel_n = 1'h1;
        // Released lines show the inverse so no stale level can pass for data.
        link.io0 = ~val;
        link.io3 = ~val;
        wait_cyc(4 * HALF);
    endtask : frame

    // ====================================================================
    // Reset pin pulse, only while deselected
    task automatic reset_pulse(input int cyc);
        wait_cyc(1);
        link.rst_n = 1'h0;
        wait_cyc(cyc);
        link.rst_n = 1'h1;
    endtask : reset_pulse

    task automatic set_io(input logic val);
        link.io0 = val;
        link.io3 = val;
    endtask : set_io
endmodule : host_ctl_model

// >>> verif/test_serial_flash_powerup_rescue_reset.sv
// Purpose: Self-checking bench for power-up, pin reset recovery and rescue.
// Assumes: Shortened counts: power-up 50, array 40, long recoveries 60 cycles.
// Notes: The host model drives the link; the bench drives supply and core status.
`timescale 1ns/1ps

module test_serial_flash_powerup_rescue_reset;
    import flash_pwr_pkg::*;

    // ====================================================================
    // Signals
    localparam logic [31:0] PUP = 32'h0000_0032;
    localparam logic [31:0] ARR = 32'h0000_0028;
    localparam logic [31:0] LONG = 32'h0000_003C;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic por_ok = 1'h0;
    logic at_min = 1'h0;
    link_t link;
    op_kind_t busy_op = OP_IDLE;
    logic dummy_first = 1'h0;
    logic exec_enable = 1'h0;
    logic exec_boot = 1'h1;
    logic core_reset, status_only, full_access, clear_wel_wip, lock_init;
    logic exec_mode, ext_spi_forced, recovering;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    host_ctl_model host (.clk(clk_sys), .link(link));

    flash_pwr_seq #(.PUP_CYCLES(PUP), .RECOV_ARRAY_CYC(ARR), .STATUS_WR_CYC(LONG),
        .NVCFG_WR_CYC(LONG), .SUBSECTOR_CYC(LONG)) uut (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SUPPLY_ABOVE_POR(por_ok),
        .SUPPLY_AT_MIN(at_min), .LINK(link), .BUSY_OP(busy_op), .DUMMY_FIRST(dummy_first),
        .EXECUTE_IN_PLACE_ENABLE(exec_enable), .EXECUTE_IN_PLACE_BOOT(exec_boot),
        .CORE_RESET(core_reset),
        .STATUS_ONLY(status_only), .FULL_ACCESS(full_access),
        .CLEAR_WEL_WIP(clear_wel_wip), .LOCK_INIT(lock_init),
        .EXECUTE_IN_PLACE_MODE(exec_mode),
        .EXT_SPI_FORCED(ext_spi_forced), .RECOVERING(recovering));

    // ====================================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // A hang would stall every scenario, so the cycle count is bounded.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            conclude();
        end
    end

    // ====================================================================
    // Scenarios
    task automatic power_up();
        int n;
        n = 0;
        por_ok = 1'h1;
        at_min = 1'h1;
        while (status_only !== 1'h1 && n < 10) begin
            step(1);
            n++;
        end
        n = 0;
        while (status_only === 1'h1 && n < 1000) begin
            check("pup no access", {core_reset, full_access}, 2'h0);
            step(1);
            n++;
        end
        check("pup length", n, PUP);
        check("boot mode", exec_mode, 1'h1);
        check("run access", full_access, 1'h1);
        check("clear pulse", {clear_wel_wip, lock_init}, 2'h3);
        step(1);
        check("clear single", {clear_wel_wip, lock_init}, 2'h0);
    endtask : power_up

    task automatic power_down();
        por_ok = 1'h0;
        at_min = 1'h0;
        step(4);
        check("down state", {core_reset, status_only, full_access}, 3'h4);
        check("down forced", ext_spi_forced, 1'h0);
    endtask : power_down

    task automatic dummy_pulse(input logic val);
        host.set_io(val);
        step(4);
        dummy_first = 1'h1;
        step(1);
        dummy_first = 1'h0;
        step(1);
    endtask : dummy_pulse

    task automatic mode_confirm();
        exec_enable = 1'h1;
        dummy_pulse(1'h0);
        check("mode keep", exec_mode, 1'h1);
        dummy_pulse(1'h1);
        check("mode end", exec_mode, 1'h0);
        exec_enable = 1'h0;
        dummy_pulse(1'h0);
        check("mode stays off", exec_mode, 1'h0);
    endtask : mode_confirm

    task automatic pin_reset(input op_kind_t op, input logic [31:0] rec);
        int n;
        int rec_n;
        n = 0;
        rec_n = 0;
        busy_op = op;
        fork
            host.reset_pulse(20);
            begin
                step(16);
                check("hold", {core_reset, recovering, full_access}, 3'h6);
            end
        join
        busy_op = OP_IDLE;
        while (full_access !== 1'h1 && n < 200) begin
            if (recovering === 1'h1 && core_reset === 1'h0) begin
                rec_n++;
            end
            step(1);
            n++;
        end
        check("recovery length", rec_n, rec);
    endtask : pin_reset

    task automatic short_pulse();
        host.reset_pulse(5);
        step(20);
        check("short pulse", {recovering, full_access}, 2'h1);
    endtask : short_pulse

    task automatic rescue(input int first, input logic val, input int second, input logic exp);
        power_down();
        power_up();
        host.frame(first, val);
        host.frame(second, 1'h1);
        check("forced", ext_spi_forced, exp);
        if (exp) begin
            check("mode after rescue", exec_mode, 1'h0);
        end
    endtask : rescue

    // ====================================================================
    // Main sequence
    initial begin
        step(6);
        sys_rst = 1'h0;
        step(3);
        check("no supply", {core_reset, status_only, full_access}, 3'h4);
        power_up();
        mode_confirm();
        pin_reset(OP_IDLE, 32'h0000_0008);
        pin_reset(OP_ARRAY, ARR);
        pin_reset(OP_STATUS_WR, LONG);
        pin_reset(OP_NVCFG_WR, LONG);
        pin_reset(OP_SUBSECTOR, LONG);
        short_pulse();
        rescue(7, 1'h1, 8, 1'h1);
        rescue(13, 1'h1, 8, 1'h1);
        rescue(25, 1'h1, 8, 1'h1);
        rescue(8, 1'h1, 7, 1'h0);
        rescue(6, 1'h1, 8, 1'h0);
        rescue(7, 1'h0, 8, 1'h0);
        power_down();
        conclude();
    end
endmodule : test_serial_flash_powerup_rescue_reset
